/* logic/aesm_axis_ctrl.sv */
// Axis encoder ratio, slip tolerance, encoder follow, queue discard,
// force-stop and go-with-done-clear handling for four axes.
// Assumes an upstream decoder delivers one parsed command per pulse and
// that the motion generator consumes the move and stop strobes here.
`include "aesm_regs.svh"
module aesm_axis_ctrl (
  input wire logic core_clk_in, // 25 MHz system clock
  input wire logic srst_in, // Synchronous reset, active high
  input wire logic cmd_valid_in, // One-cycle command strobe
  input wire aesm_pkg::aesm_cmd_t cmd_code_in, // Parsed command
  input wire logic [1:0] cmd_axis_in, // Selected axis
  input wire aesm_pkg::aesm_addr_t addr_mode_in, // Addressing mode
  input wire logic [3:0] move_axes_in, // Axes in the move (selected mode)
  input wire logic [15:0] cmd_arg0_in, // First argument
  input wire logic [15:0] cmd_arg1_in, // Second argument
  input wire logic [31:0] cmd_pos_in, // Force-stop position
  input wire logic [3:0] power_auto_in, // Power-automatic mode per axis
  input wire logic [3:0] settle_set_in, // Settle time programmed per axis
  input wire logic [3:0] enc_axis_in, // Stepper+encoder or servo per axis
  input wire logic [3:0] slot_retire_in, // Queue entry retired per axis
  input wire logic [3:0] done_set_in, // Move finished per axis
  input wire logic [127:0] target_pos_in, // Target per axis, 32 bits each
  input wire logic [127:0] enc_pos_in, // Encoder position per axis
  input wire logic [3:0] enc_step_in, // Encoder moved one count per axis
  input wire logic [3:0] enc_dir_in, // Encoder direction per axis
  output logic cmd_accept_out, // Command accepted this cycle
  output logic cmd_reject_out, // Command refused (bad arg, full or unknown code)
  output logic resp_valid_out, // Query answer valid
  output logic [31:0] resp_data_out, // Query answer
  output logic [3:0] slip_flag_out, // Sticky slip status per axis
  output logic [3:0] slip_en_out, // Detection armed per axis
  output logic [3:0] done_flag_out, // Done flags per axis
  output logic [3:0] follow_out, // Encoder follow mode per axis
  output logic [3:0] motor_step_out, // Follow-mode step pulse per axis
  output logic [3:0] motor_dir_out, // Follow-mode direction per axis
  output logic [3:0] go_out, // Start programmed move per axis
  output logic [3:0] discard_out, // Drop pending entries per axis
  output logic [3:0] force_stop_out, // Decelerate to position per axis
  output logic [31:0] force_pos_out, // Position for force-stop
  output logic [35:0] q_used_out // Queue occupancy, 9 bits per axis
);
  localparam int NA = `AESM_NUM_AXES;
  ////////////////////////////////////////////////////////////////////////
  // State record
  typedef struct packed {
    logic [NA-1:0][15:0] enc_cnt; // Ratio encoder side
    logic [NA-1:0][15:0] mot_cnt; // Ratio motor side
    logic [NA-1:0][15:0] tol; // Slip tolerance
    logic [NA-1:0] slip_en; // Detection armed
    logic [NA-1:0] slip; // Sticky slip flag
    logic [NA-1:0] done; // Done flags
    logic [NA-1:0] follow; // Follow mode
    logic [NA-1:0][15:0] acc; // Follow-mode ratio accumulator
    logic [NA-1:0] mstep; // Follow step pulse
    logic [NA-1:0] mdir; // Follow direction
    logic [NA-1:0][15:0] qused; // Queue occupancy
    logic [NA-1:0] go; // Start pulse
    logic [NA-1:0] discard; // Flush pulse
    logic [NA-1:0] fstop; // Force-stop pulse
    logic [31:0] fpos; // Force-stop position
    logic accept; // Accept pulse
    logic reject; // Reject pulse
    logic rvalid; // Answer strobe
    logic [31:0] rdata; // Answer data
  } aesm_state_t;
  aesm_state_t st_ff; // Registered state
  aesm_state_t nxt_st; // Next state
  logic [NA-1:0] slip_hit; // Live comparator results
  ////////////////////////////////////////////////////////////////////////
  // One slip comparator per axis
  genvar g;
  generate
    for (g = 0; g < NA; g++) begin : g_chk
      aesm_slip_if sif ();
      assign sif.deviation = enc_pos_in[g*32 +: 32] - target_pos_in[g*32 +: 32];
      assign sif.tol = st_ff.tol[g];
      assign sif.enc_cnt = st_ff.enc_cnt[g];
      assign sif.mot_cnt = st_ff.mot_cnt[g];
      assign sif.enable = st_ff.slip_en[g];
      assign slip_hit[g] = sif.slip;
      aesm_slip_chk u_chk (
        .s(sif.chk)
      );
    end
  endgenerate
  ////////////////////////////////////////////////////////////////////////
  // Queue cost of a queued command, zero for immediate ones
  function automatic logic [15:0] cost_of(input aesm_pkg::aesm_cmd_t c,
                                          input logic pa, input logic stl,
                                          input logic enc, input logic multi);
    logic [15:0] r;
    r = 16'h0000;
    case (c)
      aesm_pkg::CMD_SET_RATIO: r = `AESM_ER_COST;
      aesm_pkg::CMD_SET_SLIP_TOL: r = `AESM_ES_COST;
      aesm_pkg::CMD_ENC_FOLLOW: r = `AESM_ET_COST;
      aesm_pkg::CMD_FORCE_STOP_AT: begin
        r = `AESM_FP_BASE;
        if (pa) r = r + `AESM_FP_PA_ADD;
        if (stl) r = r + `AESM_SETTLE_ADD;
      end
      aesm_pkg::CMD_GO_CLEAR_DONE: begin
        r = multi ? `AESM_GD_MULTI : `AESM_GD_SINGLE;
        if (enc) r = r + `AESM_GD_ENC_ADD;
        if (pa) r = r + `AESM_GD_PA_ADD;
        if (stl) r = r + `AESM_SETTLE_ADD;
      end
      default: r = 16'h0000; // Immediate
    endcase
    return r;
  endfunction : cost_of
  ////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    logic [1:0] ax;
    logic [15:0] cost;
    logic [15:0] room;
    logic multi;
    logic [NA-1:0] clr_mask;
    logic [16:0] sum;
    ax = cmd_axis_in;
    multi = (addr_mode_in != aesm_pkg::ADDR_SINGLE);
    cost = 16'h0000;
    room = 16'h0000;
    clr_mask = '0;
    sum = 17'h00000;
    nxt_st = st_ff;
    // Pulses drop after one cycle
    nxt_st.go = '0;
    nxt_st.discard = '0;
    nxt_st.fstop = '0;
    nxt_st.mstep = '0;
    nxt_st.accept = 1'b0;
    nxt_st.reject = 1'b0;
    nxt_st.rvalid = 1'b0;
    // Retire entries executed by the motion generator
    for (int i = 0; i < NA; i++) begin
      if (slot_retire_in[i] && st_ff.qused[i] != 16'h0000) begin
        nxt_st.qused[i] = st_ff.qused[i] - 16'h0001;
      end
      // Follow mode: scale encoder counts by mot/enc, no ramp
      if (st_ff.follow[i] && enc_step_in[i]) begin
        sum = {1'b0, st_ff.acc[i]} + {1'b0, st_ff.mot_cnt[i]};
        nxt_st.mdir[i] = enc_dir_in[i];
        if (sum[15:0] >= st_ff.enc_cnt[i] && st_ff.enc_cnt[i] != 16'h0000) begin
          // One motor step per cycle at most; ratios above 1 lose steps
          nxt_st.acc[i] = sum[15:0] - st_ff.enc_cnt[i];
          nxt_st.mstep[i] = 1'b1;
        end else begin
          nxt_st.acc[i] = sum[15:0];
        end
      end
      // Armed slip raises the sticky flag
      if (slip_hit[i]) nxt_st.slip[i] = 1'b1;
      if (done_set_in[i]) nxt_st.done[i] = 1'b1;
    end
    // Command handling
    if (cmd_valid_in) begin
      cost = cost_of(cmd_code_in, power_auto_in[ax], settle_set_in[ax],
                     enc_axis_in[ax], multi);
      room = `AESM_QDEPTH - st_ff.qused[ax];
      if (cost > room) begin
        nxt_st.reject = 1'b1; // Queue full
      end else begin
        nxt_st.accept = 1'b1;
        nxt_st.qused[ax] = nxt_st.qused[ax] + cost;
        case (cmd_code_in)
          aesm_pkg::CMD_SET_RATIO: begin
            nxt_st.enc_cnt[ax] = cmd_arg0_in;
            nxt_st.mot_cnt[ax] = cmd_arg1_in;
          end
          aesm_pkg::CMD_QUERY_RATIO: begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rdata = {st_ff.mot_cnt[ax], st_ff.enc_cnt[ax]};
          end
          aesm_pkg::CMD_SET_SLIP_TOL: begin
            if (cmd_arg0_in == 16'h0000) begin
              nxt_st.accept = 1'b0; // Zero is outside the range
              nxt_st.reject = 1'b1;
              nxt_st.qused[ax] = st_ff.qused[ax];
            end else begin
              nxt_st.tol[ax] = cmd_arg0_in; // Tolerance alone arms nothing
            end
          end
          aesm_pkg::CMD_QUERY_SLIP_TOL: begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rdata = {16'h0000, st_ff.tol[ax]};
          end
          aesm_pkg::CMD_SLIP_ON: nxt_st.slip_en[ax] = 1'b1;
          aesm_pkg::CMD_HOLD_OFF: begin
            nxt_st.slip_en[ax] = 1'b0;
            nxt_st.follow[ax] = 1'b0;
          end
          aesm_pkg::CMD_LIMIT_REPORT: begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rdata = {28'h0000000, st_ff.slip | slip_hit};
          end
          aesm_pkg::CMD_ENC_FOLLOW: begin
            nxt_st.follow[ax] = 1'b1;
            nxt_st.acc[ax] = 16'h0000;
          end
          aesm_pkg::CMD_QUEUE_DISCARD: begin
            nxt_st.discard[ax] = 1'b1; // Current motion untouched
            nxt_st.qused[ax] = 16'h0000;
          end
          aesm_pkg::CMD_FORCE_STOP_AT: begin
            nxt_st.discard[ax] = 1'b1;
            nxt_st.fstop[ax] = 1'b1;
            nxt_st.fpos = cmd_pos_in;
            nxt_st.qused[ax] = cost; // Flushed, then this entry
          end
          aesm_pkg::CMD_GO_CLEAR_DONE: begin
            case (addr_mode_in)
              aesm_pkg::ADDR_SINGLE: clr_mask[ax] = 1'b1;
              aesm_pkg::ADDR_ALL: clr_mask = '1;
              aesm_pkg::ADDR_SELECTED: clr_mask = move_axes_in;
              default: clr_mask = '0;
            endcase
            // Clear and start the same axes on the same edge
            nxt_st.done = nxt_st.done & ~clr_mask;
            nxt_st.go = clr_mask;
          end
          default: begin
            nxt_st.accept = 1'b0;
            nxt_st.reject = 1'b1;
          end
        endcase
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      st_ff <= '0;
      for (int i = 0; i < NA; i++) begin
        st_ff.tol[i] <= `AESM_SLIP_TOL_RST;
        st_ff.enc_cnt[i] <= `AESM_RATIO_RST;
        st_ff.mot_cnt[i] <= `AESM_RATIO_RST;
      end
    end else begin
      st_ff <= nxt_st;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign cmd_accept_out = st_ff.accept;
  assign cmd_reject_out = st_ff.reject;
  assign resp_valid_out = st_ff.rvalid;
  assign resp_data_out = st_ff.rdata;
  assign slip_flag_out = st_ff.slip;
  assign slip_en_out = st_ff.slip_en;
  assign done_flag_out = st_ff.done;
  assign follow_out = st_ff.follow;
  assign motor_step_out = st_ff.mstep;
  assign motor_dir_out = st_ff.mdir;
  assign go_out = st_ff.go;
  assign discard_out = st_ff.discard;
  assign force_stop_out = st_ff.fstop;
  assign force_pos_out = st_ff.fpos;
  generate
    for (g = 0; g < NA; g++) begin : g_q
      assign q_used_out[g*9 +: 9] = st_ff.qused[g][8:0];
    end
  endgenerate
endmodule : aesm_axis_ctrl

/* logic/aesm_regs.svh */
// Constants for the axis encoder, slip and move-start block.
// Assumes one 25 MHz clock and a command decoder upstream.
`ifndef AESM_REGS_SVH
`define AESM_REGS_SVH
`define AESM_NUM_AXES 4
`define AESM_AXIS_W 2
`define AESM_QDEPTH 16'h0100
`define AESM_SLIP_TOL_RST 16'h0001
`define AESM_RATIO_RST 16'h0001
`define AESM_FP_BASE 16'h0003
`define AESM_FP_PA_ADD 16'h0001
`define AESM_SETTLE_ADD 16'h0003
`define AESM_GD_SINGLE 16'h0006
`define AESM_GD_MULTI 16'h0008
`define AESM_GD_ENC_ADD 16'h0003
`define AESM_GD_PA_ADD 16'h0002
`define AESM_ES_COST 16'h0002
`define AESM_ER_COST 16'h0001
`define AESM_ET_COST 16'h0002
`endif

/* logic/aesm_pkg.sv */
// Types for the axis encoder, slip and move-start block.
// Assumes the constants header is included by the design files.
package aesm_pkg;
  // Command codes presented by the upstream text decoder
  typedef enum logic [3:0] {
    CMD_NONE = 4'h0,
    CMD_SET_RATIO = 4'h1,
    CMD_QUERY_RATIO = 4'h2,
    CMD_SET_SLIP_TOL = 4'h3,
    CMD_QUERY_SLIP_TOL = 4'h4,
    CMD_SLIP_ON = 4'h5,
    CMD_HOLD_OFF = 4'h6,
    CMD_LIMIT_REPORT = 4'h7,
    CMD_ENC_FOLLOW = 4'h8,
    CMD_QUEUE_DISCARD = 4'h9,
    CMD_FORCE_STOP_AT = 4'hA,
    CMD_GO_CLEAR_DONE = 4'hB
  } aesm_cmd_t;
  // Axis addressing modes
  typedef enum logic [1:0] {
    ADDR_SINGLE = 2'h0,
    ADDR_ALL = 2'h1,
    ADDR_SELECTED = 2'h2
  } aesm_addr_t;
endpackage : aesm_pkg

/* logic/aesm_if.sv */
// Interface between the block top and its per-axis slip checker.
// Assumes both ends share core_clk_in.
interface aesm_slip_if;
  logic [31:0] deviation; // Position error in motor steps
  logic [15:0] tol; // Tolerance from the set command
  logic [15:0] enc_cnt; // Encoder side of the ratio
  logic [15:0] mot_cnt; // Motor side of the ratio
  logic enable; // Detection armed
  logic slip; // Deviation beyond tolerance
  modport top (output deviation, tol, enc_cnt, mot_cnt, enable, input slip);
  modport chk (input deviation, tol, enc_cnt, mot_cnt, enable, output slip);
endinterface : aesm_slip_if

/* logic/aesm_slip_chk.sv */
// Per-axis slip comparator.
// Assumes ratio fields are nonzero; a zero motor count is treated as 1.
`include "aesm_regs.svh"
module aesm_slip_chk (
  aesm_slip_if.chk s
);
  logic [31:0] mag; // Absolute deviation in motor steps
  logic [47:0] scaled; // Deviation rescaled to encoder counts
  logic [15:0] div; // Safe divisor
  ////////////////////////////////////////////////////////////////////////
  // Compare in encoder counts when the ratio is not unity
  always_comb begin
    mag = s.deviation[31] ? (~s.deviation + 32'h00000001) : s.deviation;
    div = (s.mot_cnt == 16'h0000) ? 16'h0001 : s.mot_cnt;
    // A divider here costs area and evaluates every cycle on the live deviation
    scaled = (48'(mag) * 48'(s.enc_cnt)) / 48'(div);
    s.slip = s.enable && (scaled > 48'(s.tol));
  end
endmodule : aesm_slip_chk

/* dv/aesm_host_model.sv */
// Host-side command source for the axis control block.
// Assumes one shared clock; commands go out one at a time.
module aesm_host_model (
  input wire logic core_clk_in, // Shared system clock
  output logic cmd_valid_in, // Command strobe
  output aesm_pkg::aesm_cmd_t cmd_code_in, // Command code
  output logic [1:0] cmd_axis_in, // Addressed axis
  output aesm_pkg::aesm_addr_t addr_mode_in, // Addressing mode
  output logic [3:0] move_axes_in, // Axes taking part
  output logic [15:0] cmd_arg0_in, // First argument
  output logic [15:0] cmd_arg1_in, // Second argument
  output logic [31:0] cmd_pos_in // Stop position
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle lines at time zero
  initial begin
    cmd_valid_in = 1'b0;
    cmd_code_in = aesm_pkg::CMD_NONE;
    cmd_axis_in = 2'h0;
    addr_mode_in = aesm_pkg::ADDR_SINGLE;
    move_axes_in = 4'h0;
    cmd_arg0_in = 16'h0000;
    cmd_arg1_in = 16'h0000;
    cmd_pos_in = 32'h0000_0000;
  end
  ////////////////////////////////////////////////////////////////////////////
  // One command per call; never a second start of one move, never a
  // stop-at on a moving servo axis
  task automatic send(input aesm_pkg::aesm_cmd_t c, input logic [1:0] ax,
                      input aesm_pkg::aesm_addr_t m, input logic [3:0] axes,
                      input logic [15:0] a0, input logic [15:0] a1, input logic [31:0] p);
    @(posedge core_clk_in);
    #1;
    cmd_valid_in = 1'b1;
    cmd_code_in = c;
    cmd_axis_in = ax;
    addr_mode_in = m;
    move_axes_in = axes;
    cmd_arg0_in = a0;
    cmd_arg1_in = a1;
    cmd_pos_in = p;
    @(posedge core_clk_in);
    #1;
    cmd_valid_in = 1'b0;
    // Stale data would hide a late capture, so invert it
    cmd_arg0_in = ~a0;
    cmd_arg1_in = ~a1;
    cmd_pos_in = ~p;
  endtask : send
endmodule : aesm_host_model

/* dv/aesm_monitor.sv */
// Port checker for the axis control block.
// Assumes one clock domain and a synchronous active-high reset.
module aesm_monitor (
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic cmd_valid_in,
  input wire aesm_pkg::aesm_cmd_t cmd_code_in,
  input wire logic [1:0] cmd_axis_in,
  input wire aesm_pkg::aesm_addr_t addr_mode_in,
  input wire logic [3:0] move_axes_in,
  input wire logic [15:0] cmd_arg0_in,
  input wire logic [31:0] cmd_pos_in,
  input wire logic [3:0] slot_retire_in,
  input wire logic cmd_accept_out,
  input wire logic cmd_reject_out,
  input wire logic resp_valid_out,
  input wire logic [3:0] slip_en_out,
  input wire logic [3:0] done_flag_out,
  input wire logic [3:0] go_out,
  input wire logic [3:0] discard_out,
  input wire logic [3:0] force_stop_out,
  input wire logic [31:0] force_pos_out,
  input wire logic [35:0] q_used_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (srst_in);
  logic v_ff; // Command taken last edge
  aesm_pkg::aesm_cmd_t c_ff; // Its code
  logic [1:0] ax_ff; // Its axis
  aesm_pkg::aesm_addr_t m_ff; // Its addressing mode
  logic [3:0] axes_ff; // Its move axes
  logic [15:0] a0_ff; // Its first argument
  logic [31:0] pos_ff; // Its position
  logic [3:0] ret_ff; // Retire pulses at that edge
  ////////////////////////////////////////////////////////////////////////////
  // Keep the last request so answers line up with their cause
  always_ff @(posedge core_clk_in) begin
    v_ff <= cmd_valid_in;
    c_ff <= cmd_code_in;
    ax_ff <= cmd_axis_in;
    m_ff <= addr_mode_in;
    axes_ff <= move_axes_in;
    a0_ff <= cmd_arg0_in;
    pos_ff <= cmd_pos_in;
    ret_ff <= slot_retire_in;
  end
  ////////////////////////////////////////////////////////////////////////////
  property p_go_cause;
    go_out != 4'h0 |-> v_ff && c_ff == aesm_pkg::CMD_GO_CLEAR_DONE;
  endproperty
  a_go_cause: assert property (p_go_cause) else $error("start without go command");
  property p_gd_single;
    v_ff && c_ff == aesm_pkg::CMD_GO_CLEAR_DONE && m_ff == aesm_pkg::ADDR_SINGLE && cmd_accept_out
      |-> go_out == (4'h1 << ax_ff) && !done_flag_out[ax_ff];
  endproperty
  a_gd_single: assert property (p_gd_single) else $error("single go wrong");
  property p_gd_all;
    v_ff && c_ff == aesm_pkg::CMD_GO_CLEAR_DONE && m_ff == aesm_pkg::ADDR_ALL && cmd_accept_out
      |-> done_flag_out == 4'h0;
  endproperty
  a_gd_all: assert property (p_gd_all) else $error("all-axes done not cleared");
  property p_gd_sel;
    v_ff && c_ff == aesm_pkg::CMD_GO_CLEAR_DONE && m_ff == aesm_pkg::ADDR_SELECTED
      && cmd_accept_out |-> (done_flag_out & axes_ff) == 4'h0;
  endproperty
  a_gd_sel: assert property (p_gd_sel) else $error("selected done not cleared");
  property p_discard;
    v_ff && c_ff == aesm_pkg::CMD_QUEUE_DISCARD && cmd_accept_out
      |-> discard_out == (4'h1 << ax_ff) && q_used_out[9 * ax_ff +: 9] == 9'h000;
  endproperty
  a_discard: assert property (p_discard) else $error("discard wrong");
  property p_fs_pos;
    force_stop_out != 4'h0 |-> v_ff && c_ff == aesm_pkg::CMD_FORCE_STOP_AT && force_pos_out == pos_ff;
  endproperty
  a_fs_pos: assert property (p_fs_pos) else $error("stop position wrong");
  property p_arm;
    (slip_en_out & ~$past(slip_en_out)) != 4'h0 |-> v_ff && c_ff == aesm_pkg::CMD_SLIP_ON;
  endproperty
  a_arm: assert property (p_arm) else $error("detection armed without command");
  property p_tol_zero;
    v_ff && c_ff == aesm_pkg::CMD_SET_SLIP_TOL && a0_ff == 16'h0000 |-> cmd_reject_out && !cmd_accept_out;
  endproperty
  a_tol_zero: assert property (p_tol_zero) else $error("zero tolerance taken");
  property p_query_free;
    v_ff && (c_ff == aesm_pkg::CMD_QUERY_RATIO || c_ff == aesm_pkg::CMD_QUERY_SLIP_TOL)
      && cmd_accept_out && ret_ff == 4'h0 |-> resp_valid_out && q_used_out == $past(q_used_out);
  endproperty
  a_query_free: assert property (p_query_free) else $error("query used queue");
endmodule : aesm_monitor

/* dv/tb.sv */
// Self-checking bench for the axis control block.
// Assumes the host model drives commands and this module the axis inputs.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic cmd_valid_in, cmd_accept_out, cmd_reject_out, resp_valid_out;
  aesm_pkg::aesm_cmd_t cmd_code_in;
  aesm_pkg::aesm_addr_t addr_mode_in;
  logic [1:0] cmd_axis_in;
  logic [15:0] cmd_arg0_in, cmd_arg1_in;
  logic [31:0] cmd_pos_in, resp_data_out, force_pos_out;
  logic [3:0] move_axes_in, power_auto_in, settle_set_in, enc_axis_in, slot_retire_in;
  logic [3:0] done_set_in, enc_step_in, enc_dir_in, slip_flag_out, slip_en_out, done_flag_out;
  logic [3:0] follow_out, motor_step_out, motor_dir_out, go_out, discard_out, force_stop_out;
  logic [127:0] target_pos_in, enc_pos_in;
  logic [35:0] q_used_out;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;
  // Clock, 40 ns period
  always #20 core_clk_in = ~core_clk_in;
  aesm_axis_ctrl uut (.*);
  aesm_host_model host (.*);
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict
  // One-cycle pulse on a per-axis input, driven after the edge
  // Passed by reference so the pulse shows on the pin while the task runs
  task automatic pulse(ref logic [3:0] sig, input logic [3:0] val);
    @(posedge core_clk_in);
    #1;
    sig = val;
    @(posedge core_clk_in);
    #1;
    sig = 4'h0;
  endtask : pulse
  // Hang guard, well above the expected run
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      print_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {power_auto_in, settle_set_in, enc_axis_in} = {4'hC, 4'hC, 4'h4};
    {slot_retire_in, done_set_in, enc_step_in, enc_dir_in} = 16'h0000;
    target_pos_in = 128'h0;
    enc_pos_in = 128'h0;
    repeat (6) @(posedge core_clk_in);
    #1;
    srst_in = 1'b0;
    host.send(aesm_pkg::CMD_QUERY_SLIP_TOL, 0, aesm_pkg::ADDR_SINGLE, 0, 0, 0, 0);
    chk(resp_data_out[15:0], 16'h0001);
    host.send(aesm_pkg::CMD_SET_SLIP_TOL, 0, aesm_pkg::ADDR_SINGLE, 0, 16'h0000, 0, 0);
    chk(cmd_reject_out, 1'b1);
    host.send(aesm_pkg::CMD_SET_SLIP_TOL, 0, aesm_pkg::ADDR_SINGLE, 0, 16'hFFFF, 0, 0);
    host.send(aesm_pkg::CMD_QUERY_SLIP_TOL, 0, aesm_pkg::ADDR_SINGLE, 0, 0, 0, 0);
    chk({resp_valid_out, resp_data_out[15:0]}, 17'h1FFFF);
    chk(q_used_out[8:0], 9'h002);
    host.send(aesm_pkg::CMD_SET_RATIO, 1, aesm_pkg::ADDR_SINGLE, 0, 16'h0002, 16'h0005, 0);
    host.send(aesm_pkg::CMD_QUERY_RATIO, 1, aesm_pkg::ADDR_SINGLE, 0, 0, 0, 0);
    chk(resp_data_out, 32'h0005_0002);
    host.send(aesm_pkg::CMD_QUEUE_DISCARD, 0, aesm_pkg::ADDR_SINGLE, 0, 0, 0, 0);
    chk({discard_out, q_used_out[8:0]}, 13'h0200);
    $display("Test settings and discard done");
    pulse(done_set_in, 4'hF);
    host.send(aesm_pkg::CMD_GO_CLEAR_DONE, 2, aesm_pkg::ADDR_SINGLE, 0, 0, 0, 0);
    chk({go_out, done_flag_out}, 8'h4B);
    chk(q_used_out[26:18], 9'h00E);
    host.send(aesm_pkg::CMD_GO_CLEAR_DONE, 0, aesm_pkg::ADDR_ALL, 0, 0, 0, 0);
    chk(done_flag_out, 4'h0);
    chk({q_used_out[26:18], q_used_out[8:0]}, {9'h00E, 9'h008});
    pulse(done_set_in, 4'hF);
    host.send(aesm_pkg::CMD_GO_CLEAR_DONE, 0, aesm_pkg::ADDR_SELECTED, 4'h3, 0, 0, 0);
    chk({go_out, done_flag_out}, 8'h3C);
    $display("Test go with done clear done");
    host.send(aesm_pkg::CMD_FORCE_STOP_AT, 3, aesm_pkg::ADDR_SINGLE, 0, 0, 0, 32'h0000_3039);
    chk({force_stop_out, force_pos_out}, 36'h8_0000_3039);
    chk(q_used_out[35:27], 9'h007);
    pulse(slot_retire_in, 4'h8);
    chk(q_used_out[35:27], 9'h006);
    $display("Test force stop done");
    host.send(aesm_pkg::CMD_SET_SLIP_TOL, 0, aesm_pkg::ADDR_SINGLE, 0, 16'h0005, 0, 0);
    enc_pos_in[31:0] = 32'h0000_0064;
    repeat (4) @(posedge core_clk_in);
    #1;
    chk(slip_flag_out[0], 1'b0);
    host.send(aesm_pkg::CMD_SLIP_ON, 0, aesm_pkg::ADDR_SINGLE, 0, 0, 0, 0);
    chk(slip_en_out[0], 1'b1);
    for (int i = 0; i < 10 && slip_flag_out[0] !== 1'b1; i++) @(posedge core_clk_in);
    #2;
    chk(slip_flag_out[0], 1'b1);
    host.send(aesm_pkg::CMD_LIMIT_REPORT, 0, aesm_pkg::ADDR_SINGLE, 0, 0, 0, 0);
    chk(resp_data_out[0], 1'b1);
    host.send(aesm_pkg::CMD_HOLD_OFF, 0, aesm_pkg::ADDR_SINGLE, 0, 0, 0, 0);
    chk(slip_en_out[0], 1'b0);
    $display("Test slip done");
    host.send(aesm_pkg::CMD_ENC_FOLLOW, 0, aesm_pkg::ADDR_SINGLE, 0, 0, 0, 0);
    chk(follow_out[0], 1'b1);
    enc_dir_in = 4'h1;
    pulse(enc_step_in, 4'h1);
    for (int i = 0; i < 5 && motor_step_out[0] !== 1'b1; i++) @(posedge core_clk_in);
    #2;
    chk({motor_step_out[0], motor_dir_out[0]}, 2'h3);
    $display("Test follow done");
    print_verdict();
  end
endmodule : tb
bind aesm_axis_ctrl aesm_monitor mon (.*);
